// File: core/gpio_port_pkg.sv
// What this block does
// - eight pins, each input, interrupt input, output
// - bit N of each word except sense controls pin N
// - direction zero: input, read returns pin level
// - input option bit: floating or pull-up
// - latch write on input leaves pin unchanged
// - interrupt-enabled input pins with option bit set raise external requests
// - edge/level sensitivity from external control bits
// - grouped interrupt pins combined by NAND
// - request latch hidden, cleared on vector fetch
// - sensitivity change clears pending request
// - direction one: drive latch, read returns latch
// - output option: push-pull or open-drain drive
// - peripheral alternate function overrides port programming
// - peripheral output forces pin to output mode
// - peripheral input pin stays readable via latch
// - pull-up only input pull-up; high driver only push-pull
// - option encoding: 0 floating/open-drain, 1 pull-up/push-pull
// - latch, direction, option reset to zero
// - input with alternate output reads alternate output
package gpio_port_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [11:0] ADDR_DATA_LATCH = 12'h000;
  localparam logic [11:0] ADDR_DIRECTION = 12'h004;
  localparam logic [11:0] ADDR_OPTION = 12'h008;
  localparam logic [11:0] ADDR_SENSE = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h010;
  localparam logic [11:0] ADDR_IRQ_STATE = 12'h014;
  localparam logic [7:0] RESET_WORD = 8'h00;
  localparam logic [1:0] RESET_SENSE = 2'h0;
  // sensitivity encodings
  localparam logic [1:0] SENSE_FALL_LOW = 2'h0;
  localparam logic [1:0] SENSE_RISE = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_BOTH = 2'h3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage : gpio_port_pkg

// File: core/gpio_pin_cell.sv
`timescale 1ns/1ps
module gpio_pin_cell (
  input wire logic dir_in,
  input wire logic opt_in,
  input wire logic latch_in,
  input wire logic alt_out_en_in,
  input wire logic alt_od_in,
  input wire logic alt_val_in,
  input wire logic pin_sync_in,
  output logic drive_low_out,
  output logic drive_high_out,
  output logic pull_up_out,
  output logic read_out
);
  logic is_out;
  logic val;
  logic push;
  always_comb begin
    is_out = alt_out_en_in | dir_in;
    val = alt_out_en_in ? alt_val_in : latch_in;
    push = alt_out_en_in ? ~alt_od_in : opt_in;
    drive_low_out = is_out & ~val;
    drive_high_out = is_out & val & push;
    pull_up_out = ~is_out & opt_in;
    if (dir_in) begin
      read_out = latch_in;
    end else if (alt_out_en_in) begin
      read_out = alt_val_in;
    end else begin
      read_out = pin_sync_in;
    end
  end
endmodule : gpio_pin_cell

// File: core/gpio_irq_group.sv
`timescale 1ns/1ps
module gpio_irq_group
  import gpio_port_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] member_in,
  input wire logic [7:0] pins_in,
  input wire logic [1:0] sense_in,
  input wire logic sense_change_in,
  input wire logic fetch_in,
  output logic pending_out
);
  logic src;
  logic src_prev_ff;
  logic ev;
  // nand of selected pins: any low pin forces it high
  assign src = ~(&(pins_in | ~member_in));
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      src_prev_ff <= 1'b0;
    end else begin
      src_prev_ff <= src;
    end
  end
  always_comb begin
    case (sense_in)
      SENSE_RISE: ev = src & ~src_prev_ff;
      SENSE_FALL: ev = ~src & src_prev_ff;
      SENSE_BOTH: ev = src ^ src_prev_ff;
      default: ev = (|member_in) & ~src; // falling edge and low level, with src low meaning pin high
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (rst_in || sense_change_in) begin
      pending_out <= 1'b0;
    end else if ((|member_in) && ev) begin
      pending_out <= 1'b1;
    end else if (fetch_in) begin
      pending_out <= 1'b0;
    end
  end
endmodule : gpio_irq_group

// File: core/gpio_port.sv
`timescale 1ns/1ps
module gpio_port
  import gpio_port_pkg::*;
#(
  parameter int unsigned PINS = 8,
  parameter logic [7:0] IRQ_PINS = 8'hFF
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [11:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe_n_out,
  output logic [PINS-1:0] pull_up_out,
  input wire logic [PINS-1:0] alt_out_en_in,
  input wire logic [PINS-1:0] alt_od_in,
  input wire logic [PINS-1:0] alt_val_in,
  output logic [PINS-1:0] alt_pin_out,
  input wire logic irq_fetch_in,
  output logic irq_req_out
);
  // ----------------------------------------
  // configuration words
  // ----------------------------------------
  logic [PINS-1:0] pin_data_latch_ff;
  logic [PINS-1:0] direction_ff;
  logic [PINS-1:0] option_ff;
  logic [1:0] sense_ff;
  logic [PINS-1:0] irq_member_ff;
  logic [PINS-1:0] sync1_ff;
  logic [PINS-1:0] sync2_ff;
  logic [PINS-1:0] read_val;
  logic [PINS-1:0] drv_low;
  logic [PINS-1:0] drv_high;
  logic [PINS-1:0] pull;
  logic wr_pend_ff;
  logic [11:0] wr_addr_ff;
  logic sense_change;
  logic pending;
  logic [PINS-1:0] irq_active;
  logic [31:0] nxt_rdata;
  wire logic addr_phase = hsel_in & hready_in & htrans_in[1];
  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end
  // ----------------------------------------
  // per-pin cells
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      gpio_pin_cell u_cell (
        .dir_in(direction_ff[g]),
        .opt_in(option_ff[g]),
        .latch_in(pin_data_latch_ff[g]),
        .alt_out_en_in(alt_out_en_in[g]),
        .alt_od_in(alt_od_in[g]),
        .alt_val_in(alt_val_in[g]),
        .pin_sync_in(sync2_ff[g]),
        .drive_low_out(drv_low[g]),
        .drive_high_out(drv_high[g]),
        .pull_up_out(pull[g]),
        .read_out(read_val[g])
      );
    end
  endgenerate
  // registered pad controls
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_out <= '0;
      pin_oe_n_out <= '1;
      pull_up_out <= '0;
      alt_pin_out <= '0;
    end else begin
      pin_out <= drv_high;
      pin_oe_n_out <= ~(drv_low | drv_high);
      pull_up_out <= pull;
      alt_pin_out <= (pin_data_latch_ff & direction_ff & ~alt_out_en_in)
        | (sync2_ff & ~(direction_ff & ~alt_out_en_in));
    end
  end
  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
    end else if (hready_in) begin
      wr_pend_ff <= addr_phase & hwrite_in;
      wr_addr_ff <= haddr_in;
    end
  end
  assign sense_change = wr_pend_ff && wr_addr_ff == ADDR_SENSE && hwdata_in[1:0] != sense_ff;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_data_latch_ff <= RESET_WORD;
      direction_ff <= RESET_WORD;
      option_ff <= RESET_WORD;
      sense_ff <= RESET_SENSE;
      irq_member_ff <= RESET_WORD;
    end else if (wr_pend_ff) begin
      if (wr_addr_ff == ADDR_DATA_LATCH) begin
        pin_data_latch_ff <= hwdata_in[PINS-1:0];
      end else if (wr_addr_ff == ADDR_DIRECTION) begin
        direction_ff <= hwdata_in[PINS-1:0];
      end else if (wr_addr_ff == ADDR_OPTION) begin
        option_ff <= hwdata_in[PINS-1:0];
      end else if (wr_addr_ff == ADDR_SENSE) begin
        sense_ff <= hwdata_in[1:0];
      end else if (wr_addr_ff == ADDR_IRQ_ENABLE) begin
        irq_member_ff <= hwdata_in[PINS-1:0] & IRQ_PINS;
      end
    end
  end
  always_comb begin
    nxt_rdata = '0;
    if (haddr_in == ADDR_DATA_LATCH) begin
      nxt_rdata[PINS-1:0] = read_val;
    end else if (haddr_in == ADDR_DIRECTION) begin
      nxt_rdata[PINS-1:0] = direction_ff;
    end else if (haddr_in == ADDR_OPTION) begin
      nxt_rdata[PINS-1:0] = option_ff;
    end else if (haddr_in == ADDR_SENSE) begin
      nxt_rdata[1:0] = sense_ff;
    end else if (haddr_in == ADDR_IRQ_ENABLE) begin
      nxt_rdata[PINS-1:0] = irq_member_ff;
    end else if (haddr_in == ADDR_IRQ_STATE) begin
      nxt_rdata[PINS-1:0] = irq_active;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hrdata_out <= '0;
    end else if (addr_phase && !hwrite_in) begin
      hrdata_out <= nxt_rdata;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hreadyout_out <= 1'b0;
      hresp_out <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
  end
  // ----------------------------------------
  // external interrupt group
  // ----------------------------------------
  // interrupt only on input pins with option set and group membership
  assign irq_active = irq_member_ff & ~direction_ff & option_ff & ~alt_out_en_in;
  gpio_irq_group u_group (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .member_in(irq_active),
    .pins_in(sync2_ff),
    .sense_in(sense_ff),
    .sense_change_in(sense_change),
    .fetch_in(irq_fetch_in),
    .pending_out(pending)
  );
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_req_out <= 1'b0;
    end else begin
      irq_req_out <= pending;
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_reset_input;
    @(posedge clk_in) rst_in |=> pin_oe_n_out == '1 && direction_ff == '0;
  endproperty
  a_reset_input: assert property (p_reset_input) else $error("pins not inputs after reset");
  property p_dir_apply;
    @(posedge clk_in) disable iff (rst_in) wr_pend_ff && wr_addr_ff == ADDR_DIRECTION
      |=> direction_ff == $past(hwdata_in[PINS-1:0]);
  endproperty
  a_dir_apply: assert property (p_dir_apply) else $error("direction not applied next cycle");
  property p_input_no_drive;
    @(posedge clk_in) disable iff (rst_in) (direction_ff[0] == 1'b0 && !alt_out_en_in[0])
      ##1 (direction_ff[0] == 1'b0 && !alt_out_en_in[0]) |-> pin_oe_n_out[0];
  endproperty
  a_input_no_drive: assert property (p_input_no_drive) else $error("input pin driven");
  property p_pull_only_input;
    @(posedge clk_in) disable iff (rst_in) pull_up_out[0] |-> $past(!direction_ff[0] && option_ff[0]);
  endproperty
  a_pull_only_input: assert property (p_pull_only_input) else $error("pull-up outside input mode");
  property p_od_float;
    @(posedge clk_in) disable iff (rst_in) ($past(direction_ff[0] && !option_ff[0] && !alt_out_en_in[0]
      && pin_data_latch_ff[0])) |-> pin_oe_n_out[0] && !pin_out[0];
  endproperty
  a_od_float: assert property (p_od_float) else $error("open drain high not floating");
  property p_alt_forces_out;
    @(posedge clk_in) disable iff (rst_in) $past(alt_out_en_in[0]) |-> !pin_oe_n_out[0];
  endproperty
  a_alt_forces_out: assert property (p_alt_forces_out) else $error("alternate output not driven");
  property p_sense_clear;
    @(posedge clk_in) disable iff (rst_in) sense_change |=> !pending;
  endproperty
  a_sense_clear: assert property (p_sense_clear) else $error("sense change kept request");
  property p_req_follow;
    @(posedge clk_in) disable iff (rst_in) pending |=> irq_req_out;
  endproperty
  a_req_follow: assert property (p_req_follow) else $error("request not presented");
endmodule : gpio_port

// File: bench/gpio_pad_model.sv
`timescale 1ns/1ps
module gpio_pad_model (
  input wire logic clk_in,
  input wire logic [7:0] drive_in,
  input wire logic [7:0] oe_n_in,
  input wire logic [7:0] pull_up_in,
  input wire logic [7:0] ext_en_in,
  input wire logic [7:0] ext_val_in,
  output logic [7:0] pad_out
);
  // --------------------------------
  // pad level resolution
  // --------------------------------
  logic [7:0] float_ff = 8'h55;
  // undriven, unpulled pads wander every cycle
  always @(posedge clk_in) begin
    float_ff <= ~float_ff;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!oe_n_in[i]) begin
        pad_out[i] = drive_in[i];
      end else if (ext_en_in[i]) begin
        pad_out[i] = ext_val_in[i];
      end else if (pull_up_in[i]) begin
        pad_out[i] = 1'b1;
      end else begin
        pad_out[i] = float_ff[i];
      end
    end
  end
endmodule : gpio_pad_model

// File: bench/gpio_port_tb.sv
`timescale 1ns/1ps
module gpio_port_tb;
  import gpio_port_pkg::*;
  logic clk_in, rst_in, hsel, hwrite, fetch, ready, hresp, irq;
  logic [1:0] htrans;
  logic [11:0] haddr;
  logic [31:0] hwdata, hrdata, rd;
  logic [7:0] pad, pout, oe_n, pull, aen, aod, aval, apin, ext_en, ext_val;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;

  gpio_port DUT (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(HSIZE_WORD), .hwdata_in(hwdata),
    .hready_in(ready), .hrdata_out(hrdata), .hreadyout_out(ready), .hresp_out(hresp),
    .pin_in(pad), .pin_out(pout), .pin_oe_n_out(oe_n), .pull_up_out(pull),
    .alt_out_en_in(aen), .alt_od_in(aod), .alt_val_in(aval), .alt_pin_out(apin),
    .irq_fetch_in(fetch), .irq_req_out(irq));
  gpio_pad_model pads (.clk_in(clk_in), .drive_in(pout), .oe_n_in(oe_n), .pull_up_in(pull),
    .ext_en_in(ext_en), .ext_val_in(ext_val), .pad_out(pad));

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fail_count++;
      end_sim();
    end
  end

  // --------------------------------
  // bus and check tasks
  // --------------------------------
  task automatic end_sim();
    if (fail_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick
  task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge clk_in); while (ready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    do @(posedge clk_in); while (ready !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask : wr
  task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
    xfer(a, 1'b0, 8'h00);
    chk(rd[7:0], exp);
  endtask : rchk
  task automatic wait_irq();
    for (int i = 0; i < 8 && irq !== 1'b1; i++) @(posedge clk_in);
    chk(8'(irq), 8'h01);
  endtask : wait_irq
  task automatic fetch_pulse();
    fetch <= 1'b1;
    tick(1);
    fetch <= 1'b0;
    tick(3);
    chk(8'(irq), 8'h00);
  endtask : fetch_pulse

  // --------------------------------
  // test sequence
  // --------------------------------
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata, fetch, aen, aod, aval, ext_en, ext_val} = '0;
    rst_in = 1'b1;
    tick(12);
    rst_in <= 1'b0;
    tick(2);
    chk(oe_n, 8'hFF);
    chk(pull, 8'h00);
    rchk(ADDR_DIRECTION, 8'h00);
    rchk(ADDR_OPTION, 8'h00);
    rchk(12'h03C, 8'h00);
    chk(rd[15:8], 8'h00);
    chk(8'(hresp), 8'h00);
    ext_en <= 8'hFF;
    ext_val <= 8'hA5;
    wr(ADDR_DATA_LATCH, 8'h3C);
    tick(3);
    chk(oe_n, 8'hFF);
    rchk(ADDR_DATA_LATCH, 8'hA5);
    ext_en <= 8'h00;
    wr(ADDR_OPTION, 8'hFF);
    tick(3);
    chk(pull, 8'hFF);
    rchk(ADDR_DATA_LATCH, 8'hFF);
    wr(ADDR_DIRECTION, 8'hFF);
    tick(1);
    chk(oe_n, 8'hFF);
    tick(1);
    chk(oe_n, 8'h00);
    chk(pout, 8'h3C);
    chk(pull, 8'h00);
    rchk(ADDR_DATA_LATCH, 8'h3C);
    wr(ADDR_OPTION, 8'h00);
    tick(2);
    chk(oe_n, 8'h3C);
    chk(pout, 8'h00);
    rchk(ADDR_DATA_LATCH, 8'h3C);
    wr(ADDR_DIRECTION, 8'h00);
    ext_en <= 8'hF0;
    ext_val <= 8'h50;
    aen <= 8'h0F;
    aod <= 8'h0C;
    aval <= 8'h0A;
    tick(4);
    chk(oe_n, 8'hF8);
    chk(pout, 8'h02);
    rchk(ADDR_DATA_LATCH, 8'h5A);
    chk(apin & 8'hF0, 8'h50);
    aen <= 8'h00;
    ext_en <= 8'h00;
    wr(ADDR_OPTION, 8'h03);
    tick(4);
    wr(ADDR_IRQ_ENABLE, 8'h03);
    wr(ADDR_SENSE, {6'h00, SENSE_BOTH});
    tick(6);
    chk(8'(irq), 8'h00);
    ext_en <= 8'h01;
    wait_irq();
    fetch_pulse();
    ext_en <= 8'h00;
    wait_irq();
    wr(ADDR_SENSE, {6'h00, SENSE_RISE});
    tick(3);
    chk(8'(irq), 8'h00);
    wr(ADDR_SENSE, {6'h00, SENSE_BOTH});
    ext_en <= 8'h02;
    wait_irq();
    fetch_pulse();
    ext_en <= 8'h03;
    tick(6);
    ext_en <= 8'h02;
    tick(6);
    chk(8'(irq), 8'h00);
    end_sim();
  end
endmodule : gpio_port_tb
